// [hdl/sow_overwrite.v]
/*
 * Sanitize overwrite command interpreter with an AXI4-Lite register file,
 * the sanitize state machine, a media write port and an interrupt output.
 * Assumes a single 20 MHz clock, media logic on the same clock, and a
 * non-volatile copy of the completion flag kept outside the block.
 */
// Our own choices: the register offsets and register access over AXI4-Lite.
// Functional notes
// - Command B4h with feature 0014h is decoded as the overwrite request.
// - Accept only if sanitize supported and state is idle, failed or succeeded.
// - Accepted overwrite writes the 32-bit pattern over every user sector.
// - Sector count bit 7 set inverts the pattern between passes.
// - Sector count bits 3:0 give the pass count; zero means sixteen.
// - Failure mode set lets a status query leave the failed state.
// - Failure mode clear: failed state aborts failure-mode-set requests until a failure-mode-clear request starts a new run.
// - Completion bit is one on success, zero on entering operation, kept over power-on.
// - Sector count bit 14 is set while an operation runs.
// - Sector count bit 13 is set while frozen.
// - Progress is a numerator over 65536, FFFFh when not running.
// - Abort bit is set if freeze-lock succeeded since the last power-on reset.
// - Abort when failed by a failure-mode-clear run and new request sets the bit.
// - Error reason byte: 00h, 01h unsanitized, 02h bad feature, 03h frozen.
// - After a successful overwrite, reads of the area are served without error.
// - Reset leaves the frozen state and returns to idle.
`timescale 1ns/1ns
`default_nettype none
`include "sow_defines.vh"

module sow_overwrite #(
   parameter LOG2_SECTORS = 4,
   parameter ADDR_W = 8
) (
   input wire aclk,
   input wire aresetn,
   input wire [ADDR_W-1:0] s_axi_awaddr,
   input wire s_axi_awvalid,
   output reg s_axi_awready,
   input wire [31:0] s_axi_wdata,
   input wire [3:0] s_axi_wstrb,
   input wire s_axi_wvalid,
   output reg s_axi_wready,
   output reg [1:0] s_axi_bresp,
   output reg s_axi_bvalid,
   input wire s_axi_bready,
   input wire [ADDR_W-1:0] s_axi_araddr,
   input wire s_axi_arvalid,
   output reg s_axi_arready,
   output reg [31:0] s_axi_rdata,
   output reg [1:0] s_axi_rresp,
   output reg s_axi_rvalid,
   input wire s_axi_rready,
   output reg media_wr_valid,
   output reg [LOG2_SECTORS-1:0] media_wr_sector,
   output reg [31:0] media_wr_data,
   input wire media_wr_ready,
   input wire media_wr_fail,
   output reg media_read_ok,
   input wire done_nv_in,
   output reg done_nv_out,
   output reg irq
);

   localparam ST_IDLE = 3'd0;
   localparam ST_FROZEN = 3'd1;
   localparam ST_RUNNING = 3'd2;
   localparam ST_FAILED = 3'd3;
   localparam ST_SUCCEEDED = 3'd4;
   localparam [LOG2_SECTORS-1:0] LAST_SECTOR = {LOG2_SECTORS{1'b1}};

   ////////////////////////////////////////////////////////////////////////////
   // Register storage.
   reg [15:0] feature_ff, scount_ff, snum_ff, cyllo_ff, cylhi_ff;
   reg [7:0] errflags_ff, cond_ff, reason_ff;
   reg [2:0] irq_stat_ff, irq_mask_ff, state_ff;
   reg [31:0] ctrl_ff, pattern_ff, wdata_ff;
   reg failmode_ff, freeze_seen_ff, done_ff, invert_ff, any_fail_ff, aw_hold_ff, w_hold_ff;
   reg [4:0] passes_ff, pass_idx_ff;
   reg [16:0] step_ff;
   reg [1:0] nv_sync_ff, nv_loaded_ff;
   reg [ADDR_W-1:0] awaddr_ff;
   reg [3:0] wstrb_ff;

   ////////////////////////////////////////////////////////////////////////////
   // Bus and command qualifiers.

   wire supported = ctrl_ff[0];
   wire wr_fire = aw_hold_ff && w_hold_ff && !s_axi_bvalid;
   wire rd_fire = s_axi_arvalid && s_axi_arready;
   wire [31:0] wmask = {{8{wstrb_ff[3]}}, {8{wstrb_ff[2]}}, {8{wstrb_ff[1]}},
      {8{wstrb_ff[0]}}};
   wire wr_cmd = wr_fire && awaddr_ff == `SOW_OFS_COMMAND && wstrb_ff[0];
   wire media_take = media_wr_valid && media_wr_ready;

   ////////////////////////////////////////////////////////////////////////////
   // Progress numerator over 65536 while running.
   wire [23:0] prog_full = pass_idx_ff * step_ff +
      ((media_wr_sector * step_ff) >> LOG2_SECTORS);
   wire [15:0] progress = (state_ff == ST_RUNNING) ? prog_full[15:0] :
      `SOW_PROGRESS_IDLE;

   // Query status byte returned in the high sector count byte.
   wire [15:0] out_scount = {done_ff, state_ff == ST_RUNNING,
      state_ff == ST_FROZEN, 13'h0000};
   wire err_shown = cond_ff[`SOW_COND_ERR];
   wire [15:0] out_snum = err_shown ? {8'h00, reason_ff} : {8'h00, progress[7:0]};
   wire [15:0] out_cyllo = err_shown ? 16'h0000 : {8'h00, progress[15:8]};

   ////////////////////////////////////////////////////////////////////////////
   // Command decode of a write to the command register.
   reg cmd_abort;
   reg [7:0] cmd_reason;
   reg cmd_start;
   reg cmd_freeze;
   reg cmd_query;
   always @* begin
      cmd_abort = 1'b0;
      cmd_reason = `SOW_RSN_NONE;
      cmd_start = 1'b0;
      cmd_freeze = 1'b0;
      cmd_query = 1'b0;
      if (wr_cmd) begin
         if (wdata_ff[7:0] != `SOW_CMD_SANITIZE || !supported) begin
            cmd_abort = 1'b1;
            cmd_reason = supported ? `SOW_RSN_NONE : `SOW_RSN_BADFEAT;
         end else if (feature_ff == `SOW_FEAT_OVERWRITE) begin
            if (state_ff == ST_FROZEN || freeze_seen_ff) begin
               cmd_abort = 1'b1;
               cmd_reason = `SOW_RSN_FROZEN;
            end else if (state_ff == ST_RUNNING) begin
               cmd_abort = 1'b1;
            end else if (state_ff == ST_FAILED && !failmode_ff &&
                  scount_ff[`SOW_SC_FAILMODE]) begin
               cmd_abort = 1'b1;
            end else begin
               cmd_start = 1'b1;
            end
         end else if (feature_ff == `SOW_FEAT_FREEZE) begin
            if (state_ff == ST_RUNNING) begin
               cmd_abort = 1'b1;
            end else begin
               cmd_freeze = 1'b1;
            end
         end else if (feature_ff == `SOW_FEAT_STATUS) begin
            cmd_query = 1'b1;
         end else begin
            cmd_abort = 1'b1;
            cmd_reason = `SOW_RSN_BADFEAT;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Overwrite engine and sanitize state machine.
   wire last_write = media_wr_sector == LAST_SECTOR && pass_idx_ff + 5'd1 == passes_ff;
   wire [4:0] req_passes = (scount_ff[`SOW_SC_COUNT_HI:0] == 4'h0) ? 5'd16 :
      {1'b0, scount_ff[`SOW_SC_COUNT_HI:0]};
   wire [31:0] req_pattern = {snum_ff[15:8], cylhi_ff[7:0], cyllo_ff[7:0],
      snum_ff[7:0]};
   wire san_end = state_ff == ST_RUNNING && media_take && last_write;
   wire san_fail = any_fail_ff || media_wr_fail;

   always @(posedge aclk) begin
      if (!aresetn) begin
         state_ff <= ST_IDLE;
         failmode_ff <= 1'b0;
         freeze_seen_ff <= 1'b0;
         invert_ff <= 1'b0;
         passes_ff <= 5'd0;
         pass_idx_ff <= 5'd0;
         pattern_ff <= 32'h0000_0000;
         any_fail_ff <= 1'b0;
         step_ff <= 17'h00000;
         media_wr_valid <= 1'b0;
         media_wr_sector <= {LOG2_SECTORS{1'b0}};
         media_wr_data <= 32'h0000_0000;
         media_read_ok <= 1'b0;
         errflags_ff <= 8'h00;
         cond_ff <= 8'h00;
         reason_ff <= `SOW_RSN_NONE;
      end else begin
         cond_ff[`SOW_COND_READY] <= 1'b1;
         cond_ff[`SOW_COND_SEEK] <= 1'b1;
         if (cmd_start) begin
            state_ff <= ST_RUNNING;
            failmode_ff <= scount_ff[`SOW_SC_FAILMODE];
            invert_ff <= scount_ff[`SOW_SC_INVERT];
            passes_ff <= req_passes;
            step_ff <= 17'h10000 / req_passes;
            pass_idx_ff <= 5'd0;
            pattern_ff <= req_pattern;
            any_fail_ff <= 1'b0;
            media_wr_valid <= 1'b1;
            media_wr_sector <= {LOG2_SECTORS{1'b0}};
            media_wr_data <= req_pattern;
            media_read_ok <= 1'b0;
         end else if (state_ff == ST_RUNNING && media_take) begin
            any_fail_ff <= san_fail;
            if (last_write) begin
               media_wr_valid <= 1'b0;
               state_ff <= san_fail ? ST_FAILED : ST_SUCCEEDED;
               media_read_ok <= !san_fail;
            end else if (media_wr_sector == LAST_SECTOR) begin
               pass_idx_ff <= pass_idx_ff + 5'd1;
               media_wr_sector <= {LOG2_SECTORS{1'b0}};
               media_wr_data <= (invert_ff && !pass_idx_ff[0]) ? ~pattern_ff :
                  pattern_ff;
            end else begin
               media_wr_sector <= media_wr_sector + 1'b1;
            end
         end
         if (cmd_freeze) begin
            state_ff <= ST_FROZEN;
            freeze_seen_ff <= 1'b1;
         end
         if (cmd_query && state_ff == ST_FAILED && failmode_ff) begin
            state_ff <= ST_IDLE;
         end
         if (wr_cmd) begin
            errflags_ff[`SOW_ERR_ABORT] <= cmd_abort;
            cond_ff[`SOW_COND_ERR] <= cmd_abort;
            reason_ff <= cmd_reason;
         end else if (san_end && san_fail) begin
            cond_ff[`SOW_COND_ERR] <= 1'b1;
            errflags_ff[`SOW_ERR_ABORT] <= 1'b1;
            reason_ff <= `SOW_RSN_UNSANITIZED;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Completion flag, restored from its non-volatile copy after reset.
   always @(posedge aclk) begin
      if (!aresetn) begin
         nv_sync_ff <= 2'b00;
         nv_loaded_ff <= 2'b00;
         done_ff <= 1'b0;
         done_nv_out <= 1'b0;
      end else begin
         nv_sync_ff <= {nv_sync_ff[0], done_nv_in};
         nv_loaded_ff <= nv_loaded_ff + {1'b0, ~&nv_loaded_ff};
         if (cmd_start) begin
            done_ff <= 1'b0;
         end else if (san_end && !san_fail) begin
            done_ff <= 1'b1;
         end else if (nv_loaded_ff == 2'd2) begin
            done_ff <= nv_sync_ff[1];
         end
         done_nv_out <= (&nv_loaded_ff) ? done_ff : nv_sync_ff[1];
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // AXI4-Lite write channel and writable registers.
   always @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_awready <= 1'b1;
         s_axi_wready <= 1'b1;
         aw_hold_ff <= 1'b0;
         w_hold_ff <= 1'b0;
         awaddr_ff <= {ADDR_W{1'b0}};
         wdata_ff <= 32'h0000_0000;
         wstrb_ff <= 4'h0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= 2'b00;
         feature_ff <= 16'h0000;
         scount_ff <= 16'h0000;
         snum_ff <= 16'h0000;
         cyllo_ff <= 16'h0000;
         cylhi_ff <= 16'h0000;
         irq_mask_ff <= `SOW_RST_MASK;
         ctrl_ff <= `SOW_RST_CTRL;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_hold_ff <= 1'b1;
            awaddr_ff <= s_axi_awaddr;
            s_axi_awready <= 1'b0;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_hold_ff <= 1'b1;
            wdata_ff <= s_axi_wdata;
            wstrb_ff <= s_axi_wstrb;
            s_axi_wready <= 1'b0;
         end
         if (wr_fire) begin
            aw_hold_ff <= 1'b0;
            w_hold_ff <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= 2'b00;
            case (awaddr_ff)
               `SOW_OFS_FEATURE: feature_ff <= (feature_ff & ~wmask[15:0]) |
                  (wdata_ff[15:0] & wmask[15:0]);
               `SOW_OFS_SCOUNT: scount_ff <= (scount_ff & ~wmask[15:0]) |
                  (wdata_ff[15:0] & wmask[15:0]);
               `SOW_OFS_SNUM: snum_ff <= (snum_ff & ~wmask[15:0]) |
                  (wdata_ff[15:0] & wmask[15:0]);
               `SOW_OFS_CYLLO: cyllo_ff <= (cyllo_ff & ~wmask[15:0]) |
                  (wdata_ff[15:0] & wmask[15:0]);
               `SOW_OFS_CYLHI: cylhi_ff <= (cylhi_ff & ~wmask[15:0]) |
                  (wdata_ff[15:0] & wmask[15:0]);
               `SOW_OFS_IRQ_MASK: irq_mask_ff <= (irq_mask_ff & ~wmask[2:0]) |
                  (wdata_ff[2:0] & wmask[2:0]);
               `SOW_OFS_CTRL: ctrl_ff <= (ctrl_ff & ~wmask) | (wdata_ff & wmask &
                  32'h0000_0001);
               `SOW_OFS_COMMAND, `SOW_OFS_COND, `SOW_OFS_ERRFLAGS, `SOW_OFS_OUT_SCOUNT,
               `SOW_OFS_OUT_SNUM, `SOW_OFS_OUT_CYLLO, `SOW_OFS_IRQ_STAT: begin
               end
               default: s_axi_bresp <= 2'b10;
            endcase
         end
         if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // AXI4-Lite read channel.
   reg [31:0] rd_val;
   reg rd_bad;
   always @* begin
      rd_val = 32'h0000_0000;
      rd_bad = 1'b0;
      case (s_axi_araddr)
         `SOW_OFS_FEATURE: rd_val = {16'h0000, feature_ff};
         `SOW_OFS_SCOUNT: rd_val = {16'h0000, scount_ff};
         `SOW_OFS_SNUM: rd_val = {16'h0000, snum_ff};
         `SOW_OFS_CYLLO: rd_val = {16'h0000, cyllo_ff};
         `SOW_OFS_CYLHI: rd_val = {16'h0000, cylhi_ff};
         `SOW_OFS_COMMAND: rd_val = 32'h0000_0000;
         `SOW_OFS_COND: rd_val = {24'h000000, cond_ff};
         `SOW_OFS_ERRFLAGS: rd_val = {24'h000000, errflags_ff};
         `SOW_OFS_OUT_SCOUNT: rd_val = {16'h0000, out_scount};
         `SOW_OFS_OUT_SNUM: rd_val = {16'h0000, out_snum};
         `SOW_OFS_OUT_CYLLO: rd_val = {16'h0000, out_cyllo};
         `SOW_OFS_IRQ_STAT: rd_val = {29'h00000000, irq_stat_ff};
         `SOW_OFS_IRQ_MASK: rd_val = {29'h00000000, irq_mask_ff};
         `SOW_OFS_CTRL: rd_val = ctrl_ff;
         default: rd_bad = 1'b1;
      endcase
   end

   always @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_arready <= 1'b1;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0000_0000;
         s_axi_rresp <= 2'b00;
      end else begin
         if (rd_fire) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rd_val;
            s_axi_rresp <= rd_bad ? 2'b10 : 2'b00;
         end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
            s_axi_arready <= 1'b1;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Sticky interrupt status, cleared by reading it; a new event wins.
   wire rd_stat = rd_fire && s_axi_araddr == `SOW_OFS_IRQ_STAT;
   wire [2:0] irq_evt = {san_end, wr_cmd && cmd_abort, wr_cmd && !cmd_abort};
   always @(posedge aclk) begin
      if (!aresetn) begin
         irq_stat_ff <= 3'h0;
         irq <= 1'b0;
      end else begin
         irq_stat_ff <= (rd_stat ? 3'h0 : irq_stat_ff) | irq_evt;
         irq <= |(((rd_stat ? 3'h0 : irq_stat_ff) | irq_evt) & irq_mask_ff);
      end
   end

endmodule

`default_nettype wire

// [inc/sow_defines.vh]
/*
 * Constants of the sanitize overwrite command block: register offsets,
 * command and feature codes, status and error bit positions, reset values.
 * Assumes it is included by bare name from the design file.
 */
`ifndef SOW_DEFINES_VH
`define SOW_DEFINES_VH

// Register byte offsets on the AXI4-Lite bus.
`define SOW_OFS_FEATURE 8'h00
`define SOW_OFS_SCOUNT 8'h04
`define SOW_OFS_SNUM 8'h08
`define SOW_OFS_CYLLO 8'h0c
`define SOW_OFS_CYLHI 8'h10
`define SOW_OFS_COMMAND 8'h14
`define SOW_OFS_COND 8'h18
`define SOW_OFS_ERRFLAGS 8'h1c
`define SOW_OFS_OUT_SCOUNT 8'h20
`define SOW_OFS_OUT_SNUM 8'h24
`define SOW_OFS_OUT_CYLLO 8'h28
`define SOW_OFS_IRQ_STAT 8'h2c
`define SOW_OFS_IRQ_MASK 8'h30
`define SOW_OFS_CTRL 8'h34

// Command and feature codes.
`define SOW_CMD_SANITIZE 8'hb4
`define SOW_FEAT_OVERWRITE 16'h0014
`define SOW_FEAT_FREEZE 16'h0020
`define SOW_FEAT_STATUS 16'h0000

// Sector count field positions of the overwrite request.
`define SOW_SC_INVERT 7
`define SOW_SC_FAILMODE 4
`define SOW_SC_COUNT_HI 3

// Sector count high byte returned by the device.
`define SOW_OSC_DONE 15
`define SOW_OSC_RUNNING 14
`define SOW_OSC_FROZEN 13

// Error flag and condition flag positions.
`define SOW_ERR_ABORT 2
`define SOW_COND_BUSY 7
`define SOW_COND_READY 6
`define SOW_COND_FAULT 5
`define SOW_COND_SEEK 4
`define SOW_COND_XFER 3
`define SOW_COND_ERR 0

// Error reason codes.
`define SOW_RSN_NONE 8'h00
`define SOW_RSN_UNSANITIZED 8'h01
`define SOW_RSN_BADFEAT 8'h02
`define SOW_RSN_FROZEN 8'h03

// Progress value outside a running operation.
`define SOW_PROGRESS_IDLE 16'hffff

// Interrupt status bit positions.
`define SOW_IRQ_CMD_DONE 0
`define SOW_IRQ_CMD_ABORT 1
`define SOW_IRQ_SAN_END 2

// Reset values.
`define SOW_RST_CTRL 32'h0000_0001
`define SOW_RST_MASK 3'h0

`endif

// [bench/sow_overwrite_chk.sv]
/* Assertion checker for the sanitize overwrite block.
   Assumes one clock and a synchronous active-low reset. */
`timescale 1ns/1ns
`default_nettype none
module sow_overwrite_chk #(
   parameter LOG2_SECTORS = 4,
   parameter ADDR_W = 8
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic s_axi_awready,
   input wire logic s_axi_wready,
   input wire logic [1:0] s_axi_bresp,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic media_wr_valid,
   input wire logic [LOG2_SECTORS-1:0] media_wr_sector,
   input wire logic [31:0] media_wr_data,
   input wire logic media_wr_ready,
   input wire logic media_read_ok,
   input wire logic irq
);
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   logic take;
   assign take = media_wr_valid & media_wr_ready;
   ////////////////////////////////////////////////////////////
   a_bresp_held: assert property (s_axi_bvalid && !s_axi_bready
      |=> s_axi_bvalid && $stable(s_axi_bresp)) else $error("write answer dropped");
   a_write_blocked: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
      else $error("write accepted while pending");
   a_resp_code: assert property (s_axi_bvalid |-> !s_axi_bresp[0])
      else $error("bad write response code");
   a_rdata_held: assert property (s_axi_rvalid && !s_axi_rready
      |=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data changed");
   a_read_answer: assert property (s_axi_arvalid && s_axi_arready
      |=> s_axi_rvalid && !s_axi_arready) else $error("read answer late");
   a_media_held: assert property (
      media_wr_valid && !media_wr_ready
      |=> media_wr_valid && $stable(media_wr_data) && $stable(media_wr_sector))
      else $error("media write changed before taken");
   a_sector_step: assert property (
      take && !(&media_wr_sector)
      |=> !media_wr_valid || media_wr_sector == $past(media_wr_sector) + 1'b1)
      else $error("sector skipped");
   a_pass_wrap: assert property (
      take && (&media_wr_sector) |=> !media_wr_valid || media_wr_sector == '0)
      else $error("pass does not restart at sector zero");
   a_pass_word: assert property (
      take && !(&media_wr_sector) |=> !media_wr_valid || $stable(media_wr_data))
      else $error("pattern changed inside a pass");
   a_read_ok_off: assert property (media_wr_valid |-> !media_read_ok)
      else $error("read allowed during overwrite");
   c_write: cover property (s_axi_bvalid && s_axi_bready);
   c_pass_end: cover property (take && (&media_wr_sector));
   c_irq: cover property ($rose(irq));
endmodule
bind sow_overwrite sow_overwrite_chk #(.LOG2_SECTORS(LOG2_SECTORS), .ADDR_W(ADDR_W))
   i_sow_overwrite_chk (
   .aclk(aclk), .aresetn(aresetn), .s_axi_awready(s_axi_awready),
   .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
   .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
   .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
   .media_wr_valid(media_wr_valid), .media_wr_sector(media_wr_sector),
   .media_wr_data(media_wr_data), .media_wr_ready(media_wr_ready),
   .media_read_ok(media_read_ok), .irq(irq)
);
`default_nettype wire

// [bench/sow_media_model.sv]
/* Media side model: takes sector writes and logs every word.
   Assumes the bench sets stall and fail injection. */
`timescale 1ns/1ns
`default_nettype none
module sow_media_model (
   input wire logic aclk,
   input wire logic valid,
   input wire logic [3:0] sector,
   input wire logic [31:0] data,
   input wire logic stall,
   input wire logic fail_en,
   output logic ready,
   output logic fail
);
   logic [31:0] words [0:255];
   int takes = 0;
   initial ready = 1'b0;
   ////////////////////////////////////////////////////////////
   always @(posedge aclk) begin
      ready <= stall ? ~ready : 1'b1;
      if (valid && ready) begin
         words[takes[7:0]] <= data;
         takes <= takes + 1;
      end
   end
   assign fail = fail_en & (sector == 4'h3);
endmodule
`default_nettype wire

// [bench/sow_overwrite_tb.sv]
/* Self-checking bench of the sanitize overwrite block.
   Assumes the media model and the bound checker. */
`timescale 1ns/1ns
`default_nettype none
`include "sow_defines.vh"
module sow_overwrite_tb;
   logic aclk = 1'b0;
   logic aresetn = 1'b0;
   logic [7:0] awaddr = 8'h00, araddr = 8'h00;
   logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   logic [31:0] wdata = 32'h0, rdat, rdata, mdata;
   logic [1:0] bresp, rresp, brsp, rrsp;
   logic awready, wready, bvalid, arready, rvalid, mvalid, mready, mfail, read_ok, nv_out, irq;
   logic stall = 1'b0, fail_en = 1'b0, nv_in = 1'b0;
   logic [3:0] msec;
   int failures = 0, num_checks = 0, cyc = 0, base = 0;
   sow_overwrite i_sow_overwrite (
      .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
      .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
      .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
      .media_wr_valid(mvalid), .media_wr_sector(msec), .media_wr_data(mdata),
      .media_wr_ready(mready), .media_wr_fail(mfail), .media_read_ok(read_ok),
      .done_nv_in(nv_in), .done_nv_out(nv_out), .irq(irq)
   );
   sow_media_model i_sow_media_model (.aclk(aclk), .valid(mvalid), .sector(msec),
      .data(mdata), .stall(stall), .fail_en(fail_en), .ready(mready), .fail(mfail));
   initial begin
      forever #25 aclk = ~aclk;
   end
   ////////////////////////////////////////////////////////////
   task automatic end_of_test;
      $display("checks %0d failures %0d", num_checks, failures);
      if (failures == 0 && num_checks > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask
   always @(posedge aclk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         failures = failures + 1;
         end_of_test;
      end
   end
   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
      num_checks++;
      if (s !== e) begin
         failures++;
         $display("BAD %s expected %h seen %h", n, e, s);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge aclk);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do begin
         @(posedge aclk);
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
      end while (awvalid && !awready || wvalid && !wready);
      do @(posedge aclk); while (!bvalid);
      brsp = bresp;
      bready <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a);
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do @(posedge aclk); while (!arready);
      arvalid <= 1'b0;
      do @(posedge aclk); while (!rvalid);
      rdat = rdata;
      rrsp = rresp;
      rready <= 1'b0;
   endtask
   task automatic ckr(input string n, input logic [7:0] a, input logic [31:0] m, e);
      rd(a);
      chk(n, e, rdat & m);
   endtask
   task automatic run(input logic [15:0] f, sc, input logic [31:0] p, input logic [2:0] ev);
      wr(`SOW_OFS_FEATURE, {16'h0, f});
      wr(`SOW_OFS_SCOUNT, {16'h0, sc});
      wr(`SOW_OFS_SNUM, {16'h0, p[31:24], p[7:0]});
      wr(`SOW_OFS_CYLLO, {24'h0, p[15:8]});
      wr(`SOW_OFS_CYLHI, {24'h0, p[23:16]});
      base = i_sow_media_model.takes;
      wr(`SOW_OFS_COMMAND, {24'h0, `SOW_CMD_SANITIZE});
      ckr("cmd event", `SOW_OFS_IRQ_STAT, 32'h3, {30'h0, ev[1:0]});
      if (ev[2]) begin
         ckr("running", `SOW_OFS_OUT_SCOUNT, 32'he000, 32'h4000);
         while (irq !== 1'b1) @(posedge aclk);
         ckr("end event", `SOW_OFS_IRQ_STAT, 32'h7, 32'h4);
         repeat (2) @(posedge aclk);
         chk("irq cleared", 32'h0, {31'h0, irq});
      end
   endtask
   task automatic ckw(input int n, input logic inv, input logic [31:0] p);
      logic [7:0] i;
      chk("takes", 32'(n * 16), 32'(i_sow_media_model.takes - base));
      for (int k = 0; k < n * 16; k++) begin
         i = 8'(base + k);
         chk("word", (inv && k[4]) ? ~p : p, i_sow_media_model.words[i]);
      end
   endtask
   task automatic t_reset;
      ckr("ctrl", `SOW_OFS_CTRL, 32'h1, 32'h1);
      ckr("mask", `SOW_OFS_IRQ_MASK, 32'h7, 32'h0);
      ckr("prog lo", `SOW_OFS_OUT_SNUM, 32'hff, 32'hff);
      ckr("prog hi", `SOW_OFS_OUT_CYLLO, 32'hff, 32'hff);
      ckr("unmapped data", 8'h3c, 32'hffff_ffff, 32'h0);
      chk("unmapped rresp", 32'h2, {30'h0, rrsp});
      wr(8'h3c, 32'h1);
      chk("unmapped bresp", 32'h2, {30'h0, brsp});
      wr(`SOW_OFS_IRQ_MASK, 32'h7);
      $display("test reset done");
   endtask
   task automatic t_invert;
      stall <= 1'b1;
      run(`SOW_FEAT_OVERWRITE, 16'h0082, 32'h1234_5678, 3'b101);
      ckw(2, 1'b1, 32'h1234_5678);
      ckr("done bits", `SOW_OFS_OUT_SCOUNT, 32'he000, 32'h8000);
      ckr("prog idle", `SOW_OFS_OUT_CYLLO, 32'hff, 32'hff);
      chk("read ok", 32'h1, {31'h0, read_ok});
      chk("nv out", 32'h1, {31'h0, nv_out});
      stall <= 1'b0;
      $display("test invert done");
   endtask
   task automatic t_sixteen;
      run(`SOW_FEAT_OVERWRITE, 16'h0000, 32'hf0e1_d2c3, 3'b101);
      ckw(16, 1'b0, 32'hf0e1_d2c3);
      $display("test sixteen done");
   endtask
   task automatic t_fail;
      fail_en <= 1'b1;
      run(`SOW_FEAT_OVERWRITE, 16'h0001, 32'ha5, 3'b101);
      fail_en <= 1'b0;
      ckr("abort bit", `SOW_OFS_ERRFLAGS, 32'h4, 32'h4);
      ckr("err cond", `SOW_OFS_COND, 32'h1, 32'h1);
      ckr("reason", `SOW_OFS_OUT_SNUM, 32'hff, 32'h01);
      ckr("done bit", `SOW_OFS_OUT_SCOUNT, 32'he000, 32'h0);
      chk("read ok", 32'h0, {31'h0, read_ok});
      run(`SOW_FEAT_STATUS, 16'h0, 32'h0, 3'b001);
      run(`SOW_FEAT_OVERWRITE, 16'h0011, 32'ha5, 3'b010);
      ckr("reason", `SOW_OFS_OUT_SNUM, 32'hff, 32'h00);
      chk("no takes", 32'h0, 32'(i_sow_media_model.takes - base));
      run(`SOW_FEAT_OVERWRITE, 16'h0001, 32'ha5, 3'b101);
      ckr("abort bit", `SOW_OFS_ERRFLAGS, 32'h4, 32'h0);
      $display("test fail done");
   endtask
   task automatic t_feature;
      run(16'h0099, 16'h0001, 32'h0, 3'b010);
      ckr("reason", `SOW_OFS_OUT_SNUM, 32'hff, 32'h02);
      wr(`SOW_OFS_CTRL, 32'h0);
      run(`SOW_FEAT_OVERWRITE, 16'h0001, 32'h0, 3'b010);
      ckr("reason", `SOW_OFS_OUT_SNUM, 32'hff, 32'h02);
      wr(`SOW_OFS_CTRL, 32'h1);
      $display("test feature done");
   endtask
   task automatic t_freeze;
      run(`SOW_FEAT_FREEZE, 16'h0000, 32'h0, 3'b001);
      ckr("frozen", `SOW_OFS_OUT_SCOUNT, 32'h2000, 32'h2000);
      run(`SOW_FEAT_OVERWRITE, 16'h0001, 32'h0, 3'b010);
      ckr("reason", `SOW_OFS_OUT_SNUM, 32'hff, 32'h03);
      ckr("abort bit", `SOW_OFS_ERRFLAGS, 32'h4, 32'h4);
      nv_in <= 1'b1;
      aresetn <= 1'b0;
      repeat (3) @(posedge aclk);
      aresetn <= 1'b1;
      wr(`SOW_OFS_IRQ_MASK, 32'h7);
      ckr("after reset", `SOW_OFS_OUT_SCOUNT, 32'he000, 32'h8000);
      run(`SOW_FEAT_OVERWRITE, 16'h0001, 32'h0, 3'b101);
      $display("test freeze done");
   endtask
   initial begin
      repeat (3) @(posedge aclk);
      aresetn <= 1'b1;
      t_reset;
      t_invert;
      t_sixteen;
      t_fail;
      t_feature;
      t_freeze;
      end_of_test;
   end
endmodule
`default_nettype wire
